/* File: common/sar_adc_pkg.sv */
// Shared constants and carrier types for the converter sequencer
package sar_adc_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] OFS_STATUS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_RESULT_HIGH    = 3'h1;
  localparam logic [2:0] OFS_RESULT_LOW     = 3'h2;
  localparam logic [2:0] OFS_CONV_CLOCK     = 3'h3;
  localparam logic [2:0] OFS_PORT_DATA      = 3'h4;
  localparam logic [2:0] OFS_PORT_DIR       = 3'h5;

  // Status and control field positions
  localparam int DONE_BIT      = 7;
  localparam int IRQ_EN_BIT    = 6;
  localparam int CONT_BIT      = 5;
  localparam int CHAN_LSB      = 0;
  localparam int CHAN_W        = 5;

  // Clock register field positions
  localparam int DIV_LSB       = 5;
  localparam int DIV_W         = 3;
  localparam int SRC_BIT       = 4;
  localparam int FMT_LSB       = 2;
  localparam int FMT_W         = 2;

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h1F;
  localparam logic [7:0] CLOCK_RESET  = 8'h00;
  localparam logic [4:0] CHAN_OFF     = 5'h1F;

  // Channel map
  localparam int          NUM_CHANNELS = 10;
  localparam logic [4:0]  CHAN_HIGH_REF = 5'h1D;
  localparam logic [4:0]  CHAN_LOW_REF  = 5'h1E;
  localparam int          NUM_PINS      = 10;

  // Conversion timing in converter cycles
  localparam int          CONV_CYCLES  = 16;
  localparam logic [4:0]  CONV_LAST    = 5'(CONV_CYCLES - 1);

  // Sample width and full-scale codes
  localparam int          RES_W        = 10;
  localparam logic [9:0]  CODE_MAX     = 10'h3FF;
  localparam logic [9:0]  CODE_MIN     = 10'h000;

  // Result formats
  typedef enum logic [1:0] {
    FMT_LEFT,
    FMT_RIGHT,
    FMT_SIGNED_LEFT,
    FMT_TRUNC8
  } result_format_t;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Formatted result pair
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_pair_t;

endpackage

/* File: rtl/sar_adc_sequencer.sv */
// Control logic of a ten-channel successive-approximation converter
// Notes on behaviour
// (RL1) Channel select field routes one of ten channels to the converter.
// (RL2) Selected shared pin leaves port logic; port writes do not reach it.
// (RL3) Reading the port bit of a pin the converter uses returns 0.
// (RL4) High reference gives 3FF, low gives 000; out-of-range saturates.
// (RL5) A status and control write starts a conversion.
// (RL6) A conversion takes 16 to 17 converter clock cycles.
// (RL7) Converter clock is bus or crystal clock, then a selectable divider.
// (RL8) Partial first cycle after the start write counts as cycle seventeen.
// (RL9) Continuous mode reloads results after every conversion, read or not.
// (RL10) Continuous mode converts back to back until the bit is cleared.
// (RL11) Done flag sets after each conversion, stays until result data read; a control write also clears it.
// (RL12) Software discards data of a conversion interrupted by a control write.
// (RL13) Four result formats chosen by two format bits in clock register.
// (RL14) Left format: top eight bits high register, bottom two in low.
// (RL15) After high read, no new result stored until low is read.
// (RL16) Right format: top two bits high register, bottom eight low register.
// (RL17) Signed left format is left format with top bit inverted.
// (RL18) Truncation: top eight bits into low register, no interlock.
// (RL19) With interrupts enabled, each finished conversion requests one.
// (RL20) With interrupts enabled the done flag stays zero.
// (RL21) Converter runs during wait mode; its interrupt can wake the MCU.
// (RL22) Software powers the converter off before wait if not needed.
// (RL23) Channel field all ones switches the converter off.
// (RL24) Any status and control write aborts and restarts conversion.
// (RL25) Pending interrupt clears on result data read or control write.
// (RL26) Reset clears continuous bit, giving single conversion mode.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module sar_adc_sequencer
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire logic                      crystal_derived_clock,
  input  wire sar_adc_pkg::reg_req_t     reg_req,
  output logic [7:0]                     reg_rdata,
  input  wire logic [9:0]                pin_level,
  output logic [9:0]                     pin_out,
  output logic [9:0]                     pin_oe_n,
  output logic [4:0]                     mux_select,
  output logic                           converter_power,
  output logic                           sample_hold,
  output logic [9:0]                     trial_code,
  input  wire logic                      comparator_high,
  input  wire logic                      wait_mode,
  output logic                           irq_request,
  output logic                           wake_request,
  output logic                           converting
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ALIGN,
    ST_RUN
  } conv_state_t;

  // Decode a register address against the port strobes
  function automatic logic hit(input logic strobe,
                               input logic [2:0] addr,
                               input logic [2:0] ofs);
    hit = strobe && (addr == ofs);
  endfunction

  // Tell whether a channel code names one of the shared pins
  function automatic logic is_pin(input logic [4:0] chan);
    is_pin = (chan < 5'(sar_adc_pkg::NUM_CHANNELS));
  endfunction

  logic                 wr_status;
  logic                 wr_clock;
  logic                 wr_pdata;
  logic                 wr_pdir;
  logic                 rd_high;
  logic                 rd_low;
  logic [7:0]           status_ff;
  logic [7:0]           clock_ff;
  logic [9:0]           port_data_ff;
  logic [9:0]           port_dir_ff;
  logic [1:0]           xclk_sync_ff;
  logic                 xclk_prev_ff;
  logic [6:0]           div_cnt_ff;
  logic [6:0]           div_limit;
  logic                 src_edge;
  logic                 adc_tick;
  conv_state_t          state_ff;
  logic [4:0]           step_ff;
  logic [9:0]           sar_ff;
  logic [9:0]           nxt_sar;
  logic                 conv_end;
  logic                 done_ff;
  logic                 irq_ff;
  logic                 lock_ff;
  sar_adc_pkg::result_pair_t result_ff;
  sar_adc_pkg::result_pair_t nxt_result;
  logic [9:0]           pin_sync1_ff;
  logic [9:0]           pin_sync2_ff;
  logic [9:0]           pin_own;
  logic [4:0]           chan;
  logic                 powered;
  logic [9:0]           code;
  logic [7:0]           rdata_ff;

  // Strobe decode, shared by the register processes other than read data and the input stages
  assign wr_status = hit(reg_req.wr, reg_req.addr,
                         sar_adc_pkg::OFS_STATUS_CONTROL);
  assign wr_clock  = hit(reg_req.wr, reg_req.addr,
                         sar_adc_pkg::OFS_CONV_CLOCK);
  assign wr_pdata  = hit(reg_req.wr, reg_req.addr,
                         sar_adc_pkg::OFS_PORT_DATA);
  assign wr_pdir   = hit(reg_req.wr, reg_req.addr,
                         sar_adc_pkg::OFS_PORT_DIR);
  assign rd_high   = hit(reg_req.rd, reg_req.addr,
                         sar_adc_pkg::OFS_RESULT_HIGH);
  assign rd_low    = hit(reg_req.rd, reg_req.addr,
                         sar_adc_pkg::OFS_RESULT_LOW);

  assign chan    = status_ff[sar_adc_pkg::CHAN_LSB +: sar_adc_pkg::CHAN_W];
  assign powered = (chan != sar_adc_pkg::CHAN_OFF); // RL23

  // Control registers; done flag bit is never stored from a write
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      status_ff <= sar_adc_pkg::STATUS_RESET; // RL26
      clock_ff  <= sar_adc_pkg::CLOCK_RESET;
    end
    else if (clk_en)
    begin
      if (wr_status)
        status_ff <= {1'b0, reg_req.wdata[6:0]};
      if (wr_clock)
        clock_ff <= reg_req.wdata;
    end
  end

  // Port data and direction, owned by port logic for non-selected pins
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      port_data_ff <= 10'h000;
      port_dir_ff  <= 10'h000;
    end
    else if (clk_en)
    begin
      if (wr_pdata)
        port_data_ff <= {2'h0, reg_req.wdata} | (port_data_ff & 10'h300);
      if (wr_pdir)
        port_dir_ff  <= {2'h0, reg_req.wdata} | (port_dir_ff & 10'h300);
    end
  end

  // One-hot ownership of the pin selected by the converter
  always_comb
  begin
    pin_own = 10'h000;
    if (powered && is_pin(chan))
      pin_own[chan[3:0]] = 1'b1; // RL1
  end

  // Converter-owned pin is input only, whatever the port registers hold
  assign pin_out  = port_data_ff & ~pin_own;           // RL2
  assign pin_oe_n = ~(port_dir_ff & ~pin_own);         // RL2
  assign mux_select      = chan;                       // RL1
  assign converter_power = powered;

  // Pin and clock inputs come from outside, so two stages first
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_sync1_ff <= 10'h000;
      pin_sync2_ff <= 10'h000;
      xclk_sync_ff <= 2'h0;
      xclk_prev_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_sync1_ff <= pin_level;
      pin_sync2_ff <= pin_sync1_ff;
      xclk_sync_ff <= {xclk_sync_ff[0], crystal_derived_clock};
      xclk_prev_ff <= xclk_sync_ff[1];
    end
  end

  // Source pick then divide by 2^n; bus clock counts every cycle
  assign src_edge = clock_ff[sar_adc_pkg::SRC_BIT] ?
                    1'b1 : (xclk_sync_ff[1] & ~xclk_prev_ff); // RL7
  assign div_limit = 7'((8'h01 << clock_ff[sar_adc_pkg::DIV_LSB +:
                         sar_adc_pkg::DIV_W]) - 8'h01);
  assign adc_tick = src_edge && (div_cnt_ff == div_limit);

  // Prescaler restarts with each start write; the first cycle is full on the bus clock, partial on the crystal clock
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      div_cnt_ff <= 7'h00;
    else if (clk_en)
    begin
      if (wr_status)
        div_cnt_ff <= 7'h00; // RL8
      else if (adc_tick)
        div_cnt_ff <= 7'h00;
      else if (src_edge)
        div_cnt_ff <= div_cnt_ff + 7'h01; // RL7
    end
  end

  // Successive approximation: trial bit per step, keep if below input.
  // The comparator follows trial_code on this clock; a two-stage sync
  // here would make each decision judge the previous trial code.
  always_comb
  begin
    nxt_sar = sar_ff;
    if (step_ff >= 5'h01 && step_ff <= 5'h0A)
    begin
      if (comparator_high)
        nxt_sar[4'hA - step_ff[3:0]] = 1'b0;
      if (step_ff < 5'h0A)
        nxt_sar[4'h9 - step_ff[3:0]] = 1'b1;
    end
  end

  // Trial code, sample phase and activity seen by the analog side
  assign trial_code  = sar_ff;
  assign sample_hold = (state_ff == ST_RUN) && (step_ff == 5'd0);
  assign converting  = (state_ff != ST_IDLE);
  assign conv_end    = (state_ff == ST_RUN) && adc_tick &&
                       (step_ff == sar_adc_pkg::CONV_LAST);

  // Sequence: align to the first full tick, then sixteen ticks
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      step_ff  <= 5'h00;
      sar_ff   <= 10'h000;
    end
    else if (clk_en)
    begin
      if (wr_status)
      begin
        // Abort whatever runs; a powered-off write leaves it idle
        state_ff <= (reg_req.wdata[4:0] != sar_adc_pkg::CHAN_OFF) ?
                    ST_ALIGN : ST_IDLE; // RL5 RL24 RL23
        step_ff  <= 5'h00;
        sar_ff   <= 10'h200;
      end
      else
      begin
        case (state_ff)
          ST_IDLE:
            step_ff <= 5'h00;
          ST_ALIGN:
            if (adc_tick)
              state_ff <= ST_RUN; // RL8
          ST_RUN:
            if (adc_tick)
            begin
              sar_ff <= nxt_sar;
              if (conv_end)
              begin
                step_ff  <= 5'h00;
                sar_ff   <= 10'h200;
                state_ff <= status_ff[sar_adc_pkg::CONT_BIT] ?
                            ST_RUN : ST_IDLE; // RL10 RL6
              end
              else
                step_ff <= step_ff + 5'h01; // RL6
            end
          default:
            state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // References force full-scale codes before formatting, so every
  // format shows the saturated value
  always_comb
  begin
    code = sar_ff;
    if (chan == sar_adc_pkg::CHAN_HIGH_REF)
      code = sar_adc_pkg::CODE_MAX; // RL4
    else if (chan == sar_adc_pkg::CHAN_LOW_REF)
      code = sar_adc_pkg::CODE_MIN; // RL4
  end

  // Format the finished code into the high/low register pair
  always_comb
  begin
    nxt_result = '0;
    case (sar_adc_pkg::result_format_t'(
          clock_ff[sar_adc_pkg::FMT_LSB +: sar_adc_pkg::FMT_W])) // RL13
      sar_adc_pkg::FMT_LEFT:
        nxt_result = {code[9:2], code[1:0], 6'h00}; // RL14
      sar_adc_pkg::FMT_RIGHT:
        nxt_result = {6'h00, code[9:8], code[7:0]}; // RL16
      sar_adc_pkg::FMT_SIGNED_LEFT:
        nxt_result = {~code[9], code[8:2], code[1:0], 6'h00}; // RL17
      sar_adc_pkg::FMT_TRUNC8:
        nxt_result = {8'h00, code[9:2]}; // RL18
      default:
        nxt_result = '0;
    endcase
  end

  // Result store; outside truncation format the high read holds the pair until the low read
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      result_ff <= '0;
      lock_ff   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (conv_end && !lock_ff)
        result_ff <= nxt_result; // RL9 RL15
      if (rd_low)
        lock_ff <= 1'b0; // RL15
      else if (rd_high && clock_ff[sar_adc_pkg::FMT_LSB +:
               sar_adc_pkg::FMT_W] != 2'(sar_adc_pkg::FMT_TRUNC8))
        lock_ff <= 1'b1; // RL15 RL18
    end
  end

  // Done flag and interrupt: a finishing conversion beats a clearing access
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      done_ff <= 1'b0;
      irq_ff  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (conv_end && !status_ff[sar_adc_pkg::IRQ_EN_BIT])
        done_ff <= 1'b1; // RL11
      else if (rd_low || rd_high || wr_status ||
               status_ff[sar_adc_pkg::IRQ_EN_BIT])
        done_ff <= 1'b0; // RL11 RL20
      if (conv_end && status_ff[sar_adc_pkg::IRQ_EN_BIT])
        irq_ff <= 1'b1; // RL19
      else if (rd_low || rd_high || wr_status)
        irq_ff <= 1'b0; // RL25
    end
  end

  // Interrupt also serves as the wake source while the CPU waits
  assign irq_request  = irq_ff;
  assign wake_request = irq_ff && wait_mode; // RL21

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata_ff <= 8'h00;
    else if (clk_en)
    begin
      if (!reg_req.rd)
        rdata_ff <= 8'h00;
      else if (reg_req.addr == sar_adc_pkg::OFS_STATUS_CONTROL)
        rdata_ff <= {done_ff, status_ff[6:0]}; // RL20
      else if (reg_req.addr == sar_adc_pkg::OFS_RESULT_HIGH)
        rdata_ff <= result_ff.high;
      else if (reg_req.addr == sar_adc_pkg::OFS_RESULT_LOW)
        rdata_ff <= result_ff.low;
      else if (reg_req.addr == sar_adc_pkg::OFS_CONV_CLOCK)
        rdata_ff <= clock_ff;
      else if (reg_req.addr == sar_adc_pkg::OFS_PORT_DATA)
        rdata_ff <= pin_sync2_ff[7:0] & ~pin_own[7:0]; // RL3
      else if (reg_req.addr == sar_adc_pkg::OFS_PORT_DIR)
        rdata_ff <= port_dir_ff[7:0];
      else
        rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule

`default_nettype wire

/* File: sim/sar_adc_sequencer_props.sv */
// Concurrent checks on the converter sequencer ports
`timescale 1ns/1ns
`default_nettype none

module sar_adc_sequencer_props
(
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic                  clk_en,
  input wire sar_adc_pkg::reg_req_t reg_req,
  input wire logic [7:0]            reg_rdata,
  input wire logic [9:0]            pin_out,
  input wire logic [9:0]            pin_oe_n,
  input wire logic [4:0]            mux_select,
  input wire logic                  converter_power,
  input wire logic                  wait_mode,
  input wire logic                  irq_request,
  input wire logic                  wake_request,
  input wire logic                  converting
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Control writes taken by the block
  logic ctl_wr;
  assign ctl_wr = clk_en && reg_req.wr
    && reg_req.addr == sar_adc_pkg::OFS_STATUS_CONTROL;

  AST_POWER_OFF: assert property (
    converter_power == (mux_select != 5'h1F))
    else $error("converter power disagrees with channel field");
  AST_PIN_TAKEN: assert property (mux_select < 5'h0A |->
    pin_oe_n[mux_select[3:0]] && !pin_out[mux_select[3:0]])
    else $error("selected pin still driven by port logic");
  AST_START: assert property (ctl_wr && reg_req.wdata[4:0] != 5'h1F
    |=> converting)
    else $error("control write did not start a conversion");
  AST_ABORT_IRQ: assert property (ctl_wr |=> !irq_request)
    else $error("interrupt survived a control write");
  AST_WAKE: assert property (wake_request == (irq_request && wait_mode))
    else $error("wake request wrong");
  AST_CONV_LEN: assert property ($fell(converting) && !$past(reg_req.wr)
    |-> $past(converting, 16))
    else $error("conversion shorter than sixteen cycles");
  AST_IRQ_CAUSE: assert property ($rose(irq_request) |-> $past(converting))
    else $error("interrupt without a conversion");
  AST_PORT_READ: assert property (clk_en && reg_req.rd
    && reg_req.addr == sar_adc_pkg::OFS_PORT_DATA && mux_select < 5'h08
    |=> reg_rdata[$past(mux_select[2:0])] == 1'b0)
    else $error("port read of converter pin not zero");

  // Main scenarios reached
  cover property ($rose(irq_request));
  cover property ($fell(converting));
  cover property ($rose(wake_request));
endmodule

bind sar_adc_sequencer sar_adc_sequencer_props u_props (.ref_clk, .rst,
  .clk_en, .reg_req, .reg_rdata, .pin_out, .pin_oe_n, .mux_select,
  .converter_power, .wait_mode, .irq_request, .wake_request, .converting);

`default_nettype wire

/* File: sim/analog_front_model.sv */
// Analog front end: channel levels and comparator facing the sequencer
`timescale 1ns/1ns
`default_nettype none

module analog_front_model
(
  input  wire logic         ref_clk,
  input  wire logic [99:0]  levels,
  input  wire logic [4:0]   mux_select,
  input  wire logic         converter_power,
  input  wire logic [9:0]   trial_code,
  output logic              comparator_high
);
  logic [9:0] vin;
  logic       junk_ff = 1'b0;

  // Off or unselected comparator toggles, so no stale level can be trusted
  always_ff @(posedge ref_clk)
    junk_ff <= !junk_ff;

  // One of ten levels reaches the comparator
  assign vin = levels[10 * (mux_select < 5'h0A ? int'(mux_select) : 0) +: 10];
  assign comparator_high = (converter_power && mux_select < 5'h0A)
    ? (trial_code > vin) : junk_ff;
endmodule

`default_nettype wire

/* File: sim/sar_adc_sequencer_bench.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none

module sar_adc_sequencer_bench;
  localparam logic [1:0] WR = 2'h0;
  localparam logic [1:0] RD = 2'h1;
  localparam logic [1:0] RI = 2'h2;
  logic                      ref_clk, rst, clk_en, xclk, wait_mode;
  logic                      comparator_high, converter_power, sample_hold;
  logic                      irq_request, wake_request, converting, rd_seen;
  logic                      sh;
  sar_adc_pkg::reg_req_t     reg_req;
  sar_adc_pkg::result_pair_t p;
  logic [7:0]                reg_rdata;
  logic [9:0]                pin_level, pin_out, pin_oe_n, trial_code;
  logic [9:0]                old_v, new_v;
  logic [4:0]                mux_select, ch;
  logic [1:0]                f;
  logic [99:0]               levels;
  logic [8:0]                exp_q[$];
  logic [8:0]                e9;
  logic [31:0]               rng = 32'h46;
  logic [31:0]               r;
  int                        err_total, checks_done, n;

  sar_adc_sequencer u_sar_adc_sequencer (.ref_clk, .rst, .clk_en,
    .crystal_derived_clock(xclk), .reg_req, .reg_rdata, .pin_level, .pin_out,
    .pin_oe_n, .mux_select, .converter_power, .sample_hold, .trial_code,
    .comparator_high, .wait_mode, .irq_request, .wake_request, .converting);
  analog_front_model u_analog_front_model (.ref_clk, .levels, .mux_select,
    .converter_power, .trial_code, .comparator_high);

  // Bus clock and an unrelated crystal clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial
  begin
    xclk = 1'b0;
    forever #310 xclk = ~xclk;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Code of a channel; the two reference channels saturate
  function automatic logic [9:0] lvl(logic [4:0] c);
    if (c == 5'h1D)
      return 10'h3FF;
    if (c == 5'h1E)
      return 10'h000;
    return levels[10 * int'(c) +: 10];
  endfunction

  function automatic sar_adc_pkg::result_pair_t fmt_pair(logic [1:0] m,
                                                         logic [9:0] c);
    case (m)
      2'h0: return {c[9:2], c[1:0], 6'h00};
      2'h1: return {6'h00, c[9:8], c[7:0]};
      2'h2: return {~c[9], c[8:2], c[1:0], 6'h00};
      default: return {8'h00, c[9:2]};
    endcase
  endfunction

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register cycle, then one idle cycle; reads note their expectation
  task automatic bus(logic [2:0] a, logic [7:0] d, logic [1:0] k);
    @(posedge ref_clk);
    if (k != WR)
      exp_q.push_back({k[1], d});
    reg_req <= '{addr: a, wdata: (k == WR) ? d : 8'h00, wr: k == WR,
                 rd: k != WR};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask

  // Counts converting cycles, bounded; ends on a falling edge
  task automatic wait_conv(input int lo, input int hi);
    n = 0;
    sh = 1'b0;
    @(negedge ref_clk);
    while (converting === 1'b1 && n < 400)
    begin
      n++;
      sh = sh | sample_hold;
      @(negedge ref_clk);
    end
    check("conv_cycles", 8'h01, {7'h00, n >= lo && n <= hi});
    check("sample_hold", 8'h01, {7'h00, sh});
  endtask

  // Read data one cycle after each read strobe
  always @(posedge ref_clk)
  begin
    if (rd_seen)
    begin
      e9 = exp_q.pop_front();
      if (!e9[8])
        check("reg_rdata", e9[7:0], reg_rdata);
    end
    rd_seen = reg_req.rd;
  end

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Guards against a hang
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    final_report();
  end

  initial
  begin
    rst = 1'b1;
    clk_en = 1'b1;
    wait_mode = 1'b0;
    reg_req = '0;
    rd_seen = 1'b0;
    err_total = 0;
    checks_done = 0;
    r = xs();
    pin_level = r[9:0];
    for (int i = 0; i < 10; i++)
    begin
      r = xs();
      levels[i * 10 +: 10] = r[9:0];
    end
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    bus(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h1F, RD);
    bus(sar_adc_pkg::OFS_CONV_CLOCK, 8'h00, RD);
    bus(3'h7, 8'hA5, WR);
    bus(3'h7, 8'h00, RD);
    // Every channel and both references, formats in rotation
    for (int i = 0; i < 12; i++)
    begin
      ch = (i < 10) ? 5'(i) : ((i == 10) ? 5'h1D : 5'h1E);
      f = 2'(i % 4);
      p = fmt_pair(f, lvl(ch));
      bus(sar_adc_pkg::OFS_CONV_CLOCK, {3'h0, 1'b1, f, 2'h0}, WR);
      bus(sar_adc_pkg::OFS_STATUS_CONTROL, {3'h0, ch}, WR);
      wait_conv(16, 17);
      bus(sar_adc_pkg::OFS_STATUS_CONTROL, {3'h4, ch}, RD);
      bus(sar_adc_pkg::OFS_RESULT_HIGH, p.high, f == 2'h3 ? RI : RD);
      bus(sar_adc_pkg::OFS_RESULT_LOW, p.low, RD);
      bus(sar_adc_pkg::OFS_STATUS_CONTROL, {3'h0, ch}, RD);
    end
    // Restart in mid-conversion on another channel
    bus(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h02, WR);
    repeat (5) @(posedge ref_clk);
    bus(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h06, WR);
    wait_conv(16, 17);
    bus(sar_adc_pkg::OFS_RESULT_LOW, 8'(lvl(5'h06) >> 2), RD);
    // Port registers do not drive the converter's pin; port data reads it as 0
    bus(sar_adc_pkg::OFS_PORT_DATA, 8'hFF, WR);
    bus(sar_adc_pkg::OFS_PORT_DIR, 8'hFF, WR);
    @(negedge ref_clk);
    check("pin_out", 8'hBF, pin_out[7:0]);
    check("pin_oe_n", 8'h40, pin_oe_n[7:0]);
    bus(sar_adc_pkg::OFS_PORT_DIR, 8'hFF, RD);
    bus(sar_adc_pkg::OFS_PORT_DATA, pin_level[7:0] & 8'hBF, RD);
    // Divided bus clock, then crystal clock
    bus(sar_adc_pkg::OFS_CONV_CLOCK, 8'h30, WR);
    bus(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h00, WR);
    wait_conv(32, 35);
    bus(sar_adc_pkg::OFS_CONV_CLOCK, 8'h00, WR);
    bus(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h00, WR);
    wait_conv(96, 112);
    // Continuous mode: interlock in left format, none in truncation
    for (int j = 0; j < 2; j++)
    begin
      f = (j == 0) ? 2'h0 : 2'h3;
      old_v = lvl(5'h04);
      bus(sar_adc_pkg::OFS_CONV_CLOCK, {3'h0, 1'b1, f, 2'h0}, WR);
      bus(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h24, WR);
      repeat (20) @(posedge ref_clk);
      p = fmt_pair(f, old_v);
      bus(sar_adc_pkg::OFS_RESULT_HIGH, p.high, f == 2'h3 ? RI : RD);
      r = xs();
      new_v = {~old_v[9], r[8:0]};
      levels[40 +: 10] = new_v;
      repeat (60) @(posedge ref_clk);
      p = fmt_pair(f, f == 2'h3 ? new_v : old_v);
      bus(sar_adc_pkg::OFS_RESULT_LOW, p.low, RD);
      repeat (40) @(posedge ref_clk);
      p = fmt_pair(f, new_v);
      bus(sar_adc_pkg::OFS_RESULT_HIGH, p.high, f == 2'h3 ? RI : RD);
      bus(sar_adc_pkg::OFS_RESULT_LOW, p.low, RD);
      bus(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h04, WR);
      wait_conv(16, 17);
    end
    // Interrupt in wait mode replaces the done flag
    bus(sar_adc_pkg::OFS_CONV_CLOCK, 8'h10, WR);
    wait_mode <= 1'b1;
    bus(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h45, WR);
    wait_conv(16, 17);
    check("irq_request", 8'h01, {7'h00, irq_request});
    check("wake_request", 8'h01, {7'h00, wake_request});
    bus(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h45, RD);
    p = fmt_pair(2'h0, lvl(5'h05));
    bus(sar_adc_pkg::OFS_RESULT_HIGH, p.high, RD);
    @(negedge ref_clk);
    check("irq_request", 8'h00, {7'h00, irq_request});
    bus(sar_adc_pkg::OFS_RESULT_LOW, p.low, RD);
    bus(sar_adc_pkg::OFS_STATUS_CONTROL, 8'h1F, WR);
    wait_mode <= 1'b0;
    repeat (20) @(negedge ref_clk);
    check("converting", 8'h00, {7'h00, converting});
    check("converter_power", 8'h00, {7'h00, converter_power});
    repeat (2) @(posedge ref_clk);
    final_report();
  end
endmodule

`default_nettype wire
